// ===== rtl/gcc_ctrl.v
/*
  Conversion controller for the general converter: register port,
  request arbitration, settling delay, converter handshake, result and
  status registers. Assumes the analog modulator returns a 12-bit code
  with a one-cycle done pulse after conv_start, all on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gcc_regs.vh"

module gcc_ctrl #(
  parameter [13:0] EXTEND_CYC    = `GCC_EXTEND_CYC,
  parameter [15:0] AUTO_UNIT_CYC = `GCC_AUTO_UNIT_CYC
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output wire        conv_irq,
  output reg  [3:0]  mux_channel,
  output wire        converter_enable,
  output wire        converter_reference_out,
  output wire [1:0]  bias_current_sel,
  output wire        vcc_range_high,
  output reg         conv_start,
  input  wire        conv_done,
  input  wire [11:0] conv_code
);

  // ==========================================================
  // states and helpers
  localparam [3:0] ST_IDLE   = 4'b0001;
  localparam [3:0] ST_SETTLE = 4'b0010;
  localparam [3:0] ST_CONV   = 4'b0100;
  localparam [3:0] ST_STORE  = 4'b1000;
  localparam [13:0] BASE_CYC = `GCC_SETTLE_BASE_CYC;

  // usable mux positions: inputs 0-2, supply 7, 10, 11, temps 12/13, 15
  function usable;
    input [3:0] ch;
    begin
      case (ch)
        4'h0, 4'h1, 4'h2, 4'h7, 4'hA, 4'hB: usable = 1'b1;
        4'hC, 4'hD: usable = 1'b1; // die temperature
        4'hF: usable = 1'b1;
        default: usable = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // register storage
  reg [7:0]  rt_ctrl_reg;
  reg [3:0]  sw_chan_reg;
  reg [11:0] sw_result_reg;
  reg [7:0]  auto_sel_reg;
  reg [7:0]  auto_ctrl_reg;
  reg [7:0]  period_reg;
  reg [11:0] thres0_reg;
  reg [11:0] thres1_reg;
  reg [11:0] auto0_reg;
  reg [11:0] auto1_reg;
  reg        flag_sw_reg;
  reg        flag_a0_reg;
  reg        flag_a1_reg;

  // ==========================================================
  // control state
  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg        sw_pend_reg;
  reg        auto_pend_reg;
  reg        auto_step_reg;
  reg        job_sw_reg;
  reg        job_slot_reg;
  reg [15:0] unit_cnt_reg;
  reg [7:0]  period_cnt_reg;
  reg [11:0] code_reg;

  wire [3:0] a_ch0  = auto_sel_reg[3:0];
  wire [3:0] a_ch1  = auto_sel_reg[7:4];
  wire       a_en0  = auto_ctrl_reg[`GCC_AC_EN0_BIT];
  wire       a_en1  = auto_ctrl_reg[`GCC_AC_EN1_BIT];
  wire       a_any  = a_en0 | a_en1;
  wire       a_both = a_en0 & a_en1;
  wire       lo_is1 = a_ch1 < a_ch0;
  wire       wr_hit = reg_wr;
  wire       sw_req = wr_hit && (reg_addr == `GCC_SW_SELECT) &&
                      reg_wdata[`GCC_SW_START_BIT] &&
                      usable(reg_wdata[3:0]);
  wire       st_clr = wr_hit && (reg_addr == `GCC_STATUS);
  wire       tick;
  wire       settle_done;

  // ==========================================================
  // periodic slot selection
  reg [3:0] auto_chan;
  reg       auto_slot;
  reg       auto_last;

  // ascending order: lower channel first, into slot zero
  always @* begin
    auto_chan = a_ch0;
    auto_slot = 1'b0;
    auto_last = 1'b1;
    if (a_both) begin
      auto_last = auto_step_reg;
      auto_slot = auto_step_reg;
      if (auto_step_reg)
        auto_chan = lo_is1 ? a_ch0 : a_ch1;
      else
        auto_chan = lo_is1 ? a_ch1 : a_ch0;
    end else if (a_en1) begin
      auto_chan = a_ch1;
      auto_slot = 1'b1;
    end
  end

  wire [11:0] thr_sel = job_slot_reg ? thres1_reg : thres0_reg;
  wire        pol_sel = job_slot_reg ? auto_ctrl_reg[`GCC_AC_POL1_BIT]
                                     : auto_ctrl_reg[`GCC_AC_POL0_BIT];
  // polarity set: at or above threshold; clear: at or below
  wire        thr_hit = pol_sel ? (code_reg >= thr_sel)
                                : (code_reg <= thr_sel);

  // ==========================================================
  // settling delay
  wire        settle_load = (state_reg == ST_IDLE) && (state_next ==
                            ST_SETTLE);
  wire [13:0] settle_val  = rt_ctrl_reg[`GCC_RT_EXTEND_BIT] ?
                            BASE_CYC + EXTEND_CYC : BASE_CYC;

  gcc_delay_timer u_settle (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load     (settle_load),
    .load_val (settle_val),
    .done     (settle_done)
  );

  // ==========================================================
  // periodic interval generator
  assign tick = a_any && (unit_cnt_reg == AUTO_UNIT_CYC - 16'h0001) &&
                (period_cnt_reg == period_reg);

  // interval is (period + 1) units; runs only while enabled
  always @(posedge ref_clk) begin
    if (sys_rst || !a_any) begin
      unit_cnt_reg   <= 16'h0000;
      period_cnt_reg <= 8'h00;
    end else if (unit_cnt_reg == AUTO_UNIT_CYC - 16'h0001) begin
      unit_cnt_reg   <= 16'h0000;
      period_cnt_reg <= tick ? 8'h00 : period_cnt_reg + 8'h01;
    end else begin
      unit_cnt_reg <= unit_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // arbitration state machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (sw_pend_reg || auto_pend_reg)
          state_next = ST_SETTLE;
      ST_SETTLE:
        if (settle_done)
          state_next = ST_CONV;
      ST_CONV:
        if (conv_done)
          state_next = ST_STORE;
      ST_STORE:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // job launch, pending requests and converter handshake
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg     <= ST_IDLE;
      sw_pend_reg   <= 1'b0;
      auto_pend_reg <= 1'b0;
      auto_step_reg <= 1'b0;
      job_sw_reg    <= 1'b0;
      job_slot_reg  <= 1'b0;
      mux_channel   <= 4'h0;
      conv_start    <= 1'b0;
      code_reg      <= 12'h000;
    end else begin
      state_reg  <= state_next;
      conv_start <= (state_reg == ST_SETTLE) && settle_done;
      if (settle_load) begin
        // asynchronous request wins over periodic
        job_sw_reg   <= sw_pend_reg;
        job_slot_reg <= auto_slot;
        mux_channel  <= sw_pend_reg ? sw_chan_reg : auto_chan;
      end
      if (state_reg == ST_CONV && conv_done)
        code_reg <= conv_code;
      // a new asynchronous request sets, completion clears
      if (sw_req)
        sw_pend_reg <= 1'b1;
      else if (state_reg == ST_STORE && job_sw_reg)
        sw_pend_reg <= 1'b0;
      // periodic tick held while busy
      if (tick)
        auto_pend_reg <= 1'b1;
      else if (!a_any)
        auto_pend_reg <= 1'b0;
      else if (state_reg == ST_STORE && !job_sw_reg && auto_last)
        auto_pend_reg <= 1'b0;
      if (!a_both)
        auto_step_reg <= 1'b0;
      else if (state_reg == ST_STORE && !job_sw_reg)
        auto_step_reg <= ~auto_step_reg;
    end
  end

  // ==========================================================
  // results and status flags
  wire store_sw   = (state_reg == ST_STORE) && job_sw_reg;
  wire store_auto = (state_reg == ST_STORE) && !job_sw_reg;
  wire set_a0     = store_auto && !job_slot_reg && thr_hit;
  wire set_a1     = store_auto && job_slot_reg && thr_hit;

  // results overwrite; flags set wins over write-one clear
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sw_result_reg <= 12'h000;
      auto0_reg     <= 12'h000;
      auto1_reg     <= 12'h000;
      flag_sw_reg   <= 1'b0;
      flag_a0_reg   <= 1'b0;
      flag_a1_reg   <= 1'b0;
    end else begin
      if (store_sw)
        sw_result_reg <= code_reg;
      if (store_auto && !job_slot_reg)
        auto0_reg <= code_reg;
      if (store_auto && job_slot_reg)
        auto1_reg <= code_reg;
      if (store_sw)
        flag_sw_reg <= 1'b1;
      else if (st_clr && reg_wdata[`GCC_ST_SW_BIT])
        flag_sw_reg <= 1'b0;
      if (set_a0)
        flag_a0_reg <= 1'b1;
      else if (st_clr && reg_wdata[`GCC_ST_AUTO0_BIT])
        flag_a0_reg <= 1'b0;
      if (set_a1)
        flag_a1_reg <= 1'b1;
      else if (st_clr && reg_wdata[`GCC_ST_AUTO1_BIT])
        flag_a1_reg <= 1'b0;
    end
  end

  assign conv_irq = flag_sw_reg | flag_a0_reg | flag_a1_reg;

  // ==========================================================
  // register writes
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rt_ctrl_reg   <= `GCC_RT_RESET;
      sw_chan_reg   <= 4'h0;
      auto_sel_reg  <= `GCC_AUTO_SEL_RESET;
      auto_ctrl_reg <= `GCC_AUTO_CTRL_RESET;
      period_reg    <= `GCC_PERIOD_RESET;
      thres0_reg    <= `GCC_THRES_RESET;
      thres1_reg    <= `GCC_THRES_RESET;
    end else if (wr_hit) begin
      case (reg_addr)
        `GCC_REALTIME_CTRL: rt_ctrl_reg   <= reg_wdata;
        `GCC_SW_SELECT:     sw_chan_reg   <= reg_wdata[3:0];
        `GCC_AUTO_SELECT:   auto_sel_reg  <= reg_wdata;
        `GCC_AUTO_CTRL:     auto_ctrl_reg <= reg_wdata;
        `GCC_AUTO_PERIOD:   period_reg    <= reg_wdata;
        `GCC_THRES0_LOW:    thres0_reg[7:0]  <= reg_wdata;
        `GCC_THRES0_HIGH:   thres0_reg[11:8] <= reg_wdata[3:0];
        `GCC_THRES1_LOW:    thres1_reg[7:0]  <= reg_wdata;
        `GCC_THRES1_HIGH:   thres1_reg[11:8] <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // register reads, data one cycle after the strobe
  wire busy = (state_reg != ST_IDLE);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `GCC_REALTIME_CTRL:  reg_rdata <= rt_ctrl_reg;
        `GCC_SW_SELECT:      reg_rdata <= {sw_pend_reg, 3'h0, sw_chan_reg};
        `GCC_SW_RESULT_LOW:  reg_rdata <= sw_result_reg[7:0];
        `GCC_SW_RESULT_HIGH: reg_rdata <= {4'h0, sw_result_reg[11:8]};
        `GCC_AUTO_SELECT:    reg_rdata <= auto_sel_reg;
        `GCC_AUTO_CTRL:      reg_rdata <= auto_ctrl_reg;
        `GCC_AUTO_PERIOD:    reg_rdata <= period_reg;
        `GCC_THRES0_LOW:     reg_rdata <= thres0_reg[7:0];
        `GCC_THRES0_HIGH:    reg_rdata <= {4'h0, thres0_reg[11:8]};
        `GCC_THRES1_LOW:     reg_rdata <= thres1_reg[7:0];
        `GCC_THRES1_HIGH:    reg_rdata <= {4'h0, thres1_reg[11:8]};
        `GCC_AUTO0_LOW:      reg_rdata <= auto0_reg[7:0];
        `GCC_AUTO0_HIGH:     reg_rdata <= {4'h0, auto0_reg[11:8]};
        `GCC_AUTO1_LOW:      reg_rdata <= auto1_reg[7:0];
        `GCC_AUTO1_HIGH:     reg_rdata <= {4'h0, auto1_reg[11:8]};
        `GCC_STATUS:         reg_rdata <= {3'h0, sw_pend_reg | auto_pend_reg,
                                           busy, flag_a1_reg, flag_a0_reg,
                                           flag_sw_reg};
        default:             reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // analog side controls
  // converter on while busy or forced; reference follows it
  assign converter_enable        = busy | rt_ctrl_reg[`GCC_RT_FORCE_BIT];
  assign converter_reference_out = converter_enable;
  // 0, 5, 15, 20 uA on channel zero
  assign bias_current_sel = rt_ctrl_reg[`GCC_RT_BIAS_LSB+1:
                                        `GCC_RT_BIAS_LSB];
  assign vcc_range_high   = rt_ctrl_reg[`GCC_RT_VCC_HIGH_BIT];

endmodule
`default_nettype wire

// ===== rtl/gcc_regs.vh
/*
  Register offsets, field positions, reset values and timing counts for
  the general converter control block. Assumes a 25 MHz core clock and
  an 8-bit register port with byte-wide registers.
*/
`ifndef GCC_REGS_VH
`define GCC_REGS_VH

// ==========================================================
// register offsets
`define GCC_REALTIME_CTRL   8'h00
`define GCC_SW_SELECT       8'h01
`define GCC_SW_RESULT_LOW   8'h02
`define GCC_SW_RESULT_HIGH  8'h03
`define GCC_AUTO_SELECT     8'h04
`define GCC_AUTO_CTRL       8'h05
`define GCC_AUTO_PERIOD     8'h06
`define GCC_THRES0_LOW      8'h07
`define GCC_THRES0_HIGH     8'h08
`define GCC_THRES1_LOW      8'h09
`define GCC_THRES1_HIGH     8'h0A
`define GCC_AUTO0_LOW       8'h0B
`define GCC_AUTO0_HIGH      8'h0C
`define GCC_AUTO1_LOW       8'h0D
`define GCC_AUTO1_HIGH      8'h0E
`define GCC_STATUS          8'h0F

// ==========================================================
// field positions
`define GCC_RT_EXTEND_BIT   0
`define GCC_RT_VCC_HIGH_BIT 1
`define GCC_RT_BIAS_LSB     2
`define GCC_RT_FORCE_BIT    4
`define GCC_SW_START_BIT    7
`define GCC_AC_EN0_BIT      0
`define GCC_AC_EN1_BIT      1
`define GCC_AC_POL0_BIT     2
`define GCC_AC_POL1_BIT     3
`define GCC_ST_SW_BIT       0
`define GCC_ST_AUTO0_BIT    1
`define GCC_ST_AUTO1_BIT    2
`define GCC_ST_BUSY_BIT     3
`define GCC_ST_PEND_BIT     4

// ==========================================================
// reset values
`define GCC_RT_RESET        8'h00
`define GCC_AUTO_SEL_RESET  8'h00
`define GCC_AUTO_CTRL_RESET 8'h00
`define GCC_PERIOD_RESET    8'h00
`define GCC_THRES_RESET     12'h000
`define GCC_CODE_MAX        12'hFFF

// ==========================================================
// timing
`define GCC_CLK_MHZ         25
`define GCC_SETTLE_BASE_US  2
`define GCC_EXTEND_US       400
`define GCC_AUTO_UNIT_US    1000
// sized to the counters they load: base 2 us, extend 400 us, unit 1 ms
`define GCC_SETTLE_BASE_CYC 14'h0032
`define GCC_EXTEND_CYC      14'h2710
`define GCC_AUTO_UNIT_CYC   16'h61A8

`endif

// ===== rtl/gcc_delay_timer.v
/*
  Down-counting delay timer for the settling interval.
  Assumes the load value fits in 14 bits and load is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module gcc_delay_timer (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        load,
  input  wire [13:0] load_val,
  output wire        done
);

  // ==========================================================
  // counter
  reg [13:0] count_reg;
  reg        run_reg;

  // counts down from the loaded value, done when it reaches zero
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      count_reg <= 14'h0000;
      run_reg   <= 1'b0;
    end else if (load) begin
      count_reg <= load_val;
      run_reg   <= 1'b1;
    end else if (run_reg) begin
      if (count_reg == 14'h0000)
        run_reg <= 1'b0;
      else
        count_reg <= count_reg - 14'h0001;
    end
  end

  assign done = run_reg && (count_reg == 14'h0000);

endmodule
`default_nettype wire

// ===== bench/gcc_ctrl_properties.sv
/*
  Concurrent checks on the ports of the converter control block.
  Assumes one clock domain and the modulator latency of at least 6 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module gcc_ctrl_properties #(
  parameter [13:0] EXTEND_CYC    = 14'd30,
  parameter [15:0] AUTO_UNIT_CYC = 16'd20
) (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        conv_irq,
  input wire logic [3:0]  mux_channel,
  input wire logic        converter_enable,
  input wire logic        converter_reference_out,
  input wire logic [1:0]  bias_current_sel,
  input wire logic        vcc_range_high,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic [11:0] conv_code
);
  default clocking cb @(posedge ref_clk); endclocking
  // ==========================================================
  // register port and converter link
  a_ref_follows:
  assert property (disable iff (sys_rst) converter_reference_out == converter_enable)
    else $error("reference output differs from converter enable");
  a_rdata_quiet:
  assert property (disable iff (sys_rst) !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_irq_cause:
  assert property (disable iff (sys_rst)
    $rose(conv_irq) |-> ($past(conv_done) || $past(conv_done, 2)))
    else $error("interrupt rose without a finished conversion");
  a_reset_idle:
  assert property (sys_rst |=> !conv_start && !conv_irq && !converter_enable
    && mux_channel == 4'h0 && reg_rdata == 8'h00)
    else $error("reset did not return the controller to idle");
  a_one_at_time:
  assert property (disable iff (sys_rst) conv_done |-> ##1 !conv_start [*8])
    else $error("new conversion started too soon after completion");
  a_mux_holds:
  assert property (disable iff (sys_rst)
    conv_start |-> ##1 $stable(mux_channel) [*4])
    else $error("channel changed during conversion");
  a_settle_first:
  assert property (disable iff (sys_rst) conv_start |-> $past(converter_enable, 40))
    else $error("conversion started without settling time");
  a_start_pulse:
  assert property (disable iff (sys_rst) conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
endmodule
bind gcc_ctrl gcc_ctrl_properties #(
  .EXTEND_CYC(EXTEND_CYC), .AUTO_UNIT_CYC(AUTO_UNIT_CYC)
) chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_irq(conv_irq), .mux_channel(mux_channel),
  .converter_enable(converter_enable),
  .converter_reference_out(converter_reference_out),
  .bias_current_sel(bias_current_sel), .vcc_range_high(vcc_range_high),
  .conv_start(conv_start), .conv_done(conv_done), .conv_code(conv_code)
);
`default_nettype wire

// ===== bench/gcc_mod_model.sv
/*
  Behavioural modulator: answers conv_start with a done pulse and a code.
  Assumes the bench supplies the code and chooses fast or slow answers.
*/
`timescale 1ns/100ps
`default_nettype none
module gcc_mod_model #(
  parameter int LAT = 6
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        conv_start,
  input  wire logic        slow,
  input  wire logic [11:0] code_in,
  output var  logic        conv_done,
  output var  logic [11:0] conv_code
);
  int cnt;
  // conversion timer, 12-bit code out, code garbled when not valid
  always @(posedge ref_clk) begin
    conv_done <= 1'b0;
    if (sys_rst) begin
      cnt       <= 0;
      conv_code <= 12'h000;
    end else if (conv_start) begin
      cnt <= slow ? LAT * 4 : LAT;
    end else if (cnt == 1) begin
      cnt       <= 0;
      conv_done <= 1'b1;
      conv_code <= code_in;
    end else begin
      if (cnt > 0) cnt <= cnt - 1;
      conv_code <= ~conv_code;
    end
  end
endmodule
`default_nettype wire

// ===== bench/gcc_ctrl_test.sv
/*
  Self-checking bench for the converter control block.
  Assumes shortened counts: extend 30 cycles, period unit 20 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gcc_regs.vh"
module gcc_ctrl_test;
  localparam int EXT = 30;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        conv_irq, converter_enable, converter_reference_out;
  logic [3:0]  mux_channel;
  logic [1:0]  bias_current_sel;
  logic        vcc_range_high, conv_start, conv_done;
  logic [11:0] conv_code;
  logic        slow = 1'b0;
  logic [11:0] code_in = 12'h000;
  int          n_errors = 0;
  int          check_count = 0;
  // ==========================================================
  // design and modulator
  gcc_ctrl #(.EXTEND_CYC(14'd30), .AUTO_UNIT_CYC(16'd20)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_irq(conv_irq), .mux_channel(mux_channel),
    .converter_enable(converter_enable),
    .converter_reference_out(converter_reference_out),
    .bias_current_sel(bias_current_sel), .vcc_range_high(vcc_range_high),
    .conv_start(conv_start), .conv_done(conv_done), .conv_code(conv_code));
  gcc_mod_model mod_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .conv_start(conv_start),
    .slow(slow), .code_in(code_in), .conv_done(conv_done),
    .conv_code(conv_code));
  always #20 ref_clk = ~ref_clk;
  // ==========================================================
  // helpers
  task automatic conclude();
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_start(output logic [3:0] ch, output int n);
    n = 0;
    do begin
      @(posedge ref_clk); #1 n++;
      if (n > 3000) begin n_errors++; conclude(); end
    end while (conv_start !== 1'b1);
    ch = mux_channel;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (conv_irq !== 1'b1) begin
      @(posedge ref_clk); #1 n++;
      if (n > 3000) begin n_errors++; conclude(); end
    end
  endtask
  task automatic no_start(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge ref_clk); #1 if (conv_start !== 1'b0) seen = 1'b1;
    end
    chk(12'h000, {11'h000, seen});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] d;
    rd(`GCC_REALTIME_CTRL, d); chk(12'h000, {4'h0, d});
    rd(`GCC_AUTO_CTRL, d); chk(12'h000, {4'h0, d});
    rd(8'h20, d); chk(12'h000, {4'h0, d});
    for (int b = 0; b < 4; b++) begin
      wr(`GCC_REALTIME_CTRL, {3'b000, 1'b1, b[1:0], 2'b10});
      #1 chk({10'h000, b[1:0]}, {10'h000, bias_current_sel});
      chk(12'h001, {11'h000, vcc_range_high});
      chk(12'h001, {11'h000, converter_reference_out});
    end
    wr(`GCC_REALTIME_CTRL, 8'h00);
    #1 chk(12'h000, {11'h000, converter_reference_out});
  endtask
  task automatic t_sw(input logic [3:0] ch, input logic [11:0] code,
                      input logic s);
    logic [3:0] c;
    logic [7:0] lo, hi;
    int n;
    code_in = code;
    slow = s;
    wr(`GCC_SW_SELECT, {4'h8, ch});
    wait_start(c, n);
    chk({8'h00, ch}, {8'h00, c});
    wait_irq();
    rd(`GCC_SW_RESULT_LOW, lo);
    rd(`GCC_SW_RESULT_HIGH, hi);
    chk(code, {hi[3:0], lo});
    chk(12'h000, {8'h00, hi[7:4]});
    rd(`GCC_STATUS, lo);
    chk(12'h001, {11'h000, lo[0]});
    wr(`GCC_STATUS, 8'h01);
    #1 chk(12'h000, {11'h000, conv_irq});
  endtask
  task automatic t_ext();
    logic [3:0] c;
    int n0, n1;
    wr(`GCC_SW_SELECT, 8'h80);
    wait_start(c, n0);
    wait_irq();
    wr(`GCC_STATUS, 8'h01);
    wr(`GCC_REALTIME_CTRL, 8'h01);
    wr(`GCC_SW_SELECT, 8'h80);
    wait_start(c, n1);
    chk(EXT[11:0], 12'(n1 - n0));
    wait_irq();
    wr(`GCC_STATUS, 8'h01);
    wr(`GCC_REALTIME_CTRL, 8'h00);
  endtask
  task automatic t_bad();
    logic [7:0] d;
    wr(`GCC_SW_SELECT, 8'h83);
    no_start(120);
    rd(`GCC_SW_SELECT, d);
    chk(12'h003, {4'h0, d});
  endtask
  task automatic t_auto();
    logic [3:0] c;
    logic [7:0] lo, hi;
    int n;
    code_in = 12'h5A3;
    wr(`GCC_AUTO_SELECT, 8'h1C);
    wr(`GCC_AUTO_CTRL, 8'h0F);
    wait_start(c, n); chk(12'h001, {8'h00, c});
    wait_start(c, n); chk(12'h00C, {8'h00, c});
    repeat (12) @(posedge ref_clk);
    wait_irq();
    rd(`GCC_AUTO0_LOW, lo); rd(`GCC_AUTO0_HIGH, hi);
    chk(12'h5A3, {hi[3:0], lo});
    rd(`GCC_STATUS, lo); chk(12'h003, {10'h000, lo[2:1]});
    code_in = 12'h3C4;
    repeat (3) wait_start(c, n);
    rd(`GCC_AUTO0_LOW, lo); rd(`GCC_AUTO0_HIGH, hi);
    chk(12'h3C4, {hi[3:0], lo});
    code_in = 12'h2B7;
    wr(`GCC_AUTO_CTRL, 8'h0B);
    wr(`GCC_STATUS, 8'h06);
    repeat (3) wait_start(c, n);
    rd(`GCC_STATUS, lo); chk(12'h002, {10'h000, lo[2:1]});
    rd(`GCC_AUTO0_LOW, lo); rd(`GCC_AUTO0_HIGH, hi);
    chk(12'h2B7, {hi[3:0], lo});
  endtask
  task automatic t_prio();
    logic [3:0] a, c;
    int n;
    wait_start(a, n);
    wr(`GCC_SW_SELECT, 8'h87);
    wait_start(c, n); chk(12'h007, {8'h00, c});
    wait_start(c, n);
    chk((a == 4'h1) ? 12'h00C : 12'h001, {8'h00, c});
  endtask
  task automatic t_reset();
    logic [3:0] c;
    logic [7:0] d;
    int n;
    wait_start(c, n);
    @(posedge ref_clk); sys_rst <= 1'b1;
    @(posedge ref_clk); sys_rst <= 1'b0;
    no_start(200);
    rd(`GCC_STATUS, d); chk(12'h000, {4'h0, d});
    rd(`GCC_AUTO_CTRL, d); chk(12'h000, {4'h0, d});
    wr(`GCC_SW_SELECT, 8'h8D);
    wait_irq();
    wr(`GCC_STATUS, 8'h01);
    t_sw(4'hD, 12'h800, 1'b0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_sw(4'h7, 12'hFFF, 1'b0);
    t_sw(4'hC, 12'h000, 1'b1);
    t_sw(4'h0, 12'h123, 1'b0);
    t_ext();
    t_bad();
    t_auto();
    t_prio();
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
